// ==== common/vts_defines.vh ====
`ifndef VTS_DEFINES_VH
`define VTS_DEFINES_VH

// Command codes
`define VTS_OP_STAY_QUIET 8'h02
`define VTS_OP_SELECT 8'h25
`define VTS_OP_RESET_READY 8'h26

// Bit positions in the request flag byte (inventory flag clear)
`define VTS_FLAG_SELECT 4
`define VTS_FLAG_ADDRESS 5
`define VTS_FLAG_OPTION 6

// Error codes carried by a response, NONE when the reply is no error
`define VTS_ERR_FORMAT 8'h02
`define VTS_ERR_OPTION 8'h03
`define VTS_ERR_NONE 8'h00

// Tag states
`define VTS_ST_READY 2'h0
`define VTS_ST_SELECTED 2'h1
`define VTS_ST_QUIET 2'h2

// Response delay window, request end to response start
`define VTS_T1_MIN_NS 318600
`define VTS_T1_MAX_NS 323300
`define VTS_CLK_PERIOD_NS 10
`define VTS_T1_MIN_CYC \
  ((`VTS_T1_MIN_NS + `VTS_CLK_PERIOD_NS - 1) / `VTS_CLK_PERIOD_NS)
`define VTS_T1_MAX_CYC (`VTS_T1_MAX_NS / `VTS_CLK_PERIOD_NS)

// Widths
`define VTS_UID_W 64
`define VTS_CNT_W 16

`endif

// ==== logic/vts_resp_timer.v ====
`timescale 1ns/1ps
`default_nettype none
`include "vts_defines.vh"

module vts_resp_timer #(
  parameter integer DELAY_CYC = `VTS_T1_MIN_CYC,
  parameter integer CNT_W = `VTS_CNT_W
) (
  input wire sys_clk_in,
  input wire arst_n_in,
  input wire start_in,
  input wire cancel_in,
  output reg done_out
);

  // Load one short: the caller registers done once more
  localparam [31:0] LOAD_FULL = DELAY_CYC - 1;
  localparam [CNT_W-1:0] LOAD = LOAD_FULL[CNT_W-1:0];
  localparam [CNT_W-1:0] ONE = {{(CNT_W-1){1'b0}}, 1'b1};

  reg [CNT_W-1:0] cnt;
  reg busy;

  always @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt <= {CNT_W{1'b0}};
      busy <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        cnt <= LOAD;
        busy <= 1'b1;
      end else if (cancel_in) begin
        busy <= 1'b0;
      end else if (busy) begin
        cnt <= cnt - ONE;
        if (cnt == ONE) begin
          busy <= 1'b0;
          done_out <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ==== logic/vts_state_cmd.v ====
`timescale 1ns/1ps
`default_nettype none
`include "vts_defines.vh"

module vts_state_cmd #(
  parameter integer T1_MIN_CYC = `VTS_T1_MIN_CYC,
  parameter integer UID_W = `VTS_UID_W,
  parameter integer CNT_W = `VTS_CNT_W
) (
  input wire sys_clk_in,
  input wire arst_n_in,
  input wire req_valid_in,
  input wire [7:0] request_flag_byte_in,
  input wire [7:0] req_opcode_in,
  input wire [UID_W-1:0] req_uid_in,
  input wire req_format_err_in,
  input wire [UID_W-1:0] tag_uid_in,
  output reg [1:0] tag_state_out,
  output reg inv_enable_out,
  output reg resp_start_out,
  output reg resp_error_out,
  output reg [7:0] resp_err_code_out
);

  reg [1:0] state;
  reg pend_error;
  reg [7:0] pend_code;

  reg [1:0] next_state;
  reg next_reply;
  reg next_error;
  reg [7:0] next_code;

  wire addr_mode;
  wire sel_mode;
  wire opt_set;
  wire uid_match;
  wire fmt_err;
  wire timer_done;
  wire is_sel;

  assign addr_mode = request_flag_byte_in[`VTS_FLAG_ADDRESS];
  assign sel_mode = request_flag_byte_in[`VTS_FLAG_SELECT];
  assign opt_set = request_flag_byte_in[`VTS_FLAG_OPTION];
  assign uid_match = (req_uid_in == tag_uid_in);
  assign is_sel = (state == `VTS_ST_SELECTED);
  // Address and select flags together cannot be honoured, so count it
  // as a malformed request rather than guess which one was meant
  assign fmt_err = req_format_err_in | (addr_mode & sel_mode);

  always @* begin
    next_state = state;
    next_reply = 1'b0;
    next_error = 1'b0;
    next_code = `VTS_ERR_NONE;
    if (req_valid_in) begin
      case (req_opcode_in)
        `VTS_OP_STAY_QUIET: begin
          // No reply on any path, errors included
          if (!fmt_err && !opt_set && addr_mode && uid_match) begin
            next_state = `VTS_ST_QUIET;
          end
        end
        `VTS_OP_SELECT: begin
          if (addr_mode && uid_match) begin
            next_reply = 1'b1;
            if (fmt_err) begin
              next_error = 1'b1;
              next_code = `VTS_ERR_FORMAT;
            end else if (opt_set) begin
              next_error = 1'b1;
              next_code = `VTS_ERR_OPTION;
            end else begin
              next_state = `VTS_ST_SELECTED;
            end
          end else if (addr_mode && !fmt_err && is_sel) begin
            next_state = `VTS_ST_READY;
          end
          // Non-addressed or foreign select otherwise ignored
        end
        `VTS_OP_RESET_READY: begin
          if ((addr_mode && uid_match) ||
              (!addr_mode && !sel_mode && !is_sel) ||
              (sel_mode && !addr_mode && is_sel)) begin
            next_reply = 1'b1;
            if (fmt_err) begin
              next_error = 1'b1;
              next_code = `VTS_ERR_FORMAT;
            end else if (opt_set) begin
              next_error = 1'b1;
              next_code = `VTS_ERR_OPTION;
            end else begin
              next_state = `VTS_ST_READY;
            end
          end else if (addr_mode && !fmt_err && is_sel) begin
            next_state = `VTS_ST_READY;
          end
          // Foreign address in Ready or Quiet: no change
        end
        default: begin
          next_state = state;
        end
      endcase
    end
  end

  // A request that gets a reply restarts the delay and any other request cancels it;
  // a reply still pending from an earlier request is dropped because the reader has moved on
  vts_resp_timer #(
    .DELAY_CYC(T1_MIN_CYC),
    .CNT_W(CNT_W)
  ) u_timer (
    .sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .start_in(next_reply),
    .cancel_in(req_valid_in),
    .done_out(timer_done)
  );

  always @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= `VTS_ST_READY;
      tag_state_out <= `VTS_ST_READY;
      inv_enable_out <= 1'b1;
      pend_error <= 1'b0;
      pend_code <= `VTS_ERR_NONE;
    end else begin
      state <= next_state;
      tag_state_out <= next_state;
      inv_enable_out <= (next_state == `VTS_ST_READY) ||
                        (next_state == `VTS_ST_SELECTED);
      if (next_reply) begin
        pend_error <= next_error;
        pend_code <= next_code;
      end
    end
  end

  // Reply starts at the short end of the window, leaving the margin
  // up to the long end for the frame encoder's own latency
  always @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      resp_start_out <= 1'b0;
      resp_error_out <= 1'b0;
      resp_err_code_out <= `VTS_ERR_NONE;
    end else begin
      resp_start_out <= timer_done;
      if (timer_done) begin
        resp_error_out <= pend_error;
        resp_err_code_out <= pend_code;
      end
    end
  end

endmodule
`default_nettype wire

// ==== verification/vts_state_cmd_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module vts_chk #(parameter integer T1_MIN_CYC = 4) (
  input wire sys_clk_in,
  input wire arst_n_in,
  input wire req_valid_in,
  input wire [7:0] request_flag_byte_in,
  input wire [7:0] req_opcode_in,
  input wire [63:0] req_uid_in,
  input wire [63:0] tag_uid_in,
  input wire [1:0] tag_state_out,
  input wire inv_enable_out,
  input wire resp_start_out,
  input wire resp_error_out,
  input wire [7:0] resp_err_code_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);
  wire m = req_uid_in == tag_uid_in;
  a_quiet_entry: assert property (tag_state_out == 2 && $past(tag_state_out) != 2 |-> $past(req_valid_in) && $past(req_opcode_in) == 8'h02 && $past(m)) else $error("quiet without own stay-quiet");
  a_select_entry: assert property (tag_state_out == 1 && $past(tag_state_out) != 1 |-> $past(req_valid_in) && $past(req_opcode_in) == 8'h25 && $past(m)) else $error("selected without own select");
  a_quiet_silent: assert property (req_valid_in && req_opcode_in == 8'h02 |=> !resp_start_out [*4]) else $error("reply to stay-quiet");
  a_reply_delay: assert property (resp_start_out |-> $past(req_valid_in, T1_MIN_CYC + 1)) else $error("reply off its delay");
  a_pulse_single: assert property (resp_start_out |=> !resp_start_out) else $error("reply pulse too long");
  a_error_code: assert property (resp_start_out |-> (resp_error_out ? resp_err_code_out inside {8'h02, 8'h03} : resp_err_code_out == 8'h00)) else $error("bad reply code");
  a_inv_tracks: assert property (inv_enable_out == (tag_state_out != 2'h2)) else $error("inventory enable wrong");
  a_foreign_keep: assert property (req_valid_in && request_flag_byte_in[5] && !m && tag_state_out != 2'h1 |=> $stable(tag_state_out)) else $error("foreign request moved state");
endmodule
bind vts_state_cmd vts_chk #(.T1_MIN_CYC(T1_MIN_CYC)) u_chk (.*);
`default_nettype wire

// ==== verification/vts_reader.sv ====
`timescale 1ns/1ps
`default_nettype none
module vts_reader (
  input wire sys_clk_in,
  output var logic req_valid_in,
  output var logic [7:0] request_flag_byte_in,
  output var logic [7:0] req_opcode_in,
  output var logic [63:0] req_uid_in,
  output var logic req_format_err_in
);
  initial {req_valid_in, request_flag_byte_in, req_opcode_in} = 0;
  initial {req_uid_in, req_format_err_in} = 0;
  // Called at a falling edge; every mode is sent, also ones a tag must refuse
  task automatic send(input [7:0] op, fl, input [63:0] uid, input fe);
    req_valid_in = 1;
    req_opcode_in = op;
    request_flag_byte_in = fl;
    req_uid_in = uid;
    req_format_err_in = fe;
    @(negedge sys_clk_in);
    req_valid_in = 0;
    // Inverted leftovers so a stale frame never looks valid
    req_uid_in = ~uid;
    req_opcode_in = ~op;
  endtask
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam integer T1 = 4;
  logic sys_clk_in = 0;
  logic arst_n_in = 0;
  logic [63:0] tag_uid_in = 64'h5a3c_0f96_1e2d_7b48;
  wire req_valid_in, req_format_err_in;
  wire [7:0] request_flag_byte_in, req_opcode_in, resp_err_code_out;
  wire [63:0] req_uid_in;
  wire [1:0] tag_state_out;
  wire inv_enable_out, resp_start_out, resp_error_out;
  integer err_total = 0, samples_checked = 0, cyc = 0;
  always #5 sys_clk_in = ~sys_clk_in;
  vts_reader rdr (.*);
  vts_state_cmd #(.T1_MIN_CYC(T1)) dut (.*);
  task automatic chk(input string n, input logic [63:0] s, e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge sys_clk_in) if (++cyc > 6000) begin
    err_total++;
    print_verdict;
  end
  initial begin
    logic [7:0] op, fl, code;
    logic a, s, o, e, m, t, rep;
    integer st, g, i, k;
    st = 0;
    repeat (10) @(negedge sys_clk_in);
    arst_n_in = 1;
    void'($urandom(32'hfa2e));
    for (i = 0; i < 500; i++) begin
      k = $urandom % 4;
      op = k == 0 ? 8'h02 : k == 1 ? 8'h25 : k == 2 ? 8'h26 : 8'h01;
      fl = {1'b0, 3'($urandom), 4'h0};
      {a, s, o} = {fl[5], fl[4], fl[6]};
      e = ($urandom % 4 == 0) | (a & s);
      m = $urandom % 2;
      t = 0;
      rep = 0;
      if (op == 8'h02 && a && m && !e && !o) st = 2;
      if (op == 8'h25) t = a & m;
      if (op == 8'h26) t = a & m | !a & !s & st != 1 | s & !a & st == 1;
      if (!t && (op == 8'h25 || op == 8'h26) && a && !m && !e && st == 1)
        st = 0;
      code = e ? 8'h02 : o ? 8'h03 : 8'h00;
      if (t) rep = 1;
      if (t && !e && !o) st = op == 8'h25;
      rdr.send(op, {fl[7:4], 4'h0} | 8'(e & !(a & s) ? 0 : 0),
        m ? tag_uid_in : tag_uid_in ^ {32'h0, $urandom | 1}, e & !(a & s));
      chk("state", tag_state_out, st);
      chk("inv", inv_enable_out, st != 2);
      // Reply shows one cycle after T1; a gap of T1 would hide it, and T1-1 would put it in the next request's first sample
      g = $urandom % 5 + 1;
      if (g == T1 - 1 || g == T1) g = T1 + 1;
      for (k = 1; k <= g; k++) begin
        chk("reply", resp_start_out, rep && k == T1 + 1 && g > T1);
        if (resp_start_out === 1'b1) begin
          chk("error", resp_error_out, code != 0);
          chk("code", resp_err_code_out, code);
        end
        @(negedge sys_clk_in);
      end
    end
    $display("random command test done");
    print_verdict;
  end
endmodule
`default_nettype wire
